// [logic/rxbg_pkg.sv]
// Shared constants for the receive baseband and gain configuration block.
`default_nettype none
package rxbg_pkg;
  // ==========================================================================
  // Register offsets on the serial control interface.
  localparam logic [7:0] OFS_RX_FILTER_BW = 8'h22;
  localparam logic [7:0] OFS_LOW_GAIN_OFS = 8'h23;
  localparam logic [7:0] OFS_GAIN_SW_TH = 8'h24;
  localparam logic [7:0] OFS_RSSI_UPPER = 8'h25;
  localparam logic [7:0] OFS_RSSI_LOWER = 8'h26;
  localparam logic [7:0] OFS_BB_CHAIN = 8'h27;
  // ==========================================================================
  // Values after reset; undefined fields come up as zero.
  localparam logic [7:0] RST_RX_FILTER_BW = 8'h00;
  localparam logic [7:0] RST_LOW_GAIN_OFS = 8'h00;
  localparam logic [7:0] RST_GAIN_SW_TH = 8'h00;
  localparam logic [7:0] RST_RSSI_UPPER = 8'h00;
  localparam logic [7:0] RST_RSSI_LOWER = 8'h00;
  localparam logic [7:0] RST_BB_CHAIN = 8'h00;
  // ==========================================================================
  // Field positions.
  localparam int ASK_SEL_BIT = 7;
  localparam int CHAN_FILTER_BW_SEL_MSB = 6;
  localparam int CHAN_FILTER_BW_SEL_LSB = 4;
  localparam int RSSI_FC_MSB = 3;
  localparam int OFS_MSB = 6;
  localparam int HOLD_MSB = 7;
  localparam int HOLD_LSB = 6;
  localparam int SETTLE_MSB = 5;
  localparam int SETTLE_LSB = 4;
  localparam int BB_FC_MSB = 3;
  // Gain switch control flag value that enables the automatic switch.
  localparam logic [1:0] GAIN_SW_AUTO = 2'h1;
  // ==========================================================================
  // Timing: sixteen timebase ticks make one chip width.
  localparam logic [4:0] TICKS_PER_CHIP = 5'h10;
  // Deglitcher hold-off in ticks for codes 00, 01, 10, 11.
  localparam logic [2:0] HOLD_TICKS_0 = 3'h0;
  localparam logic [2:0] HOLD_TICKS_1 = 3'h2;
  localparam logic [2:0] HOLD_TICKS_2 = 3'h3;
  localparam logic [2:0] HOLD_TICKS_3 = 3'h4;
  // Channel filter bandwidths in kHz.
  localparam logic [8:0] BW_300 = 9'h12C;
  localparam logic [8:0] BW_200 = 9'h0C8;
  localparam logic [8:0] BW_150 = 9'h096;
  localparam logic [8:0] BW_100 = 9'h064;
  localparam logic [8:0] BW_75 = 9'h04B;
  localparam logic [8:0] BW_50 = 9'h032;
  localparam logic [8:0] BW_RSVD = 9'h000;
  // ==========================================================================
  // Baseband settling sequencer states, Gray along the usual path.
  typedef enum logic [1:0] {
    SET_IDLE = 2'b00,
    SET_WAIT = 2'b01,
    SET_DONE = 2'b11
  } rxbg_settle_t;
endpackage
`default_nettype wire

// [logic/rxbg_deglitch.sv]
// Deglitcher that locks the slicer output for a hold-off after each transition.
`timescale 1ns/1ps
`default_nettype none
module rxbg_deglitch (
  // Clock and reset.
  input wire logic clk,
  input wire logic nrst,
  // Timebase and configuration.
  input wire logic tick16,
  input wire logic [1:0] hold_len,
  // Data.
  input wire logic slicer_in,
  output logic data_out
);
  // ==========================================================================
  // Hold-off decode.
  logic [2:0] hold_ticks; // Lock length in sixteenths of a chip.
  logic [2:0] lock_q; // Remaining lock ticks.

  // Translate the two-bit length code into sixteenth-chip ticks.
  always_comb begin
    case (hold_len)
      2'b00: hold_ticks = rxbg_pkg::HOLD_TICKS_0;
      2'b01: hold_ticks = rxbg_pkg::HOLD_TICKS_1;
      2'b10: hold_ticks = rxbg_pkg::HOLD_TICKS_2;
      default: hold_ticks = rxbg_pkg::HOLD_TICKS_3;
    endcase
  end

  // ==========================================================================
  // Output follows the slicer unless locked; a change starts a new lock.
  // Counting whole ticks means the lock may end up to one tick early, never late.
  always_ff @(posedge clk or negedge nrst) begin
    if (!nrst) begin
      data_out <= 1'b0;
      lock_q <= 3'h0;
    end else if (lock_q != 3'h0) begin
      if (tick16) begin
        lock_q <= lock_q - 3'h1;
      end
    end else if (slicer_in != data_out) begin
      data_out <= slicer_in;
      lock_q <= hold_ticks;
    end
  end
endmodule
`default_nettype wire

// [logic/rxbg_top.sv]
// Receive baseband and gain configuration registers with their control logic.
`timescale 1ns/1ps
`default_nettype none
// Behaviour
// - Top bandwidth bit selects ASK demodulator path.
// - Decode bandwidth field into six channel widths.
// - Low gain adds seven-bit offset to RSSI.
// - Wakeup search overthreshold with flags 01 lowers gain.
// - Compare RSSI against upper and lower thresholds.
// - Baseband valid follows IF valid by 2(1+n) chips.
// - Pessimistic search measures only after baseband valid.
// - Deglitcher holds off 0,2,3,4 sixteenths chip.
// - Baseband filter corner from control low nibble.
// - RSSI filter corner from bandwidth low nibble.
// - Gain modes use receiver gain register nibbles.
module rxbg_top #(
  parameter int DW = 16
) (
  // Clock and reset.
  input wire logic CLK,
  input wire logic NRST,
  // Register port from the serial control interface.
  input wire logic [7:0] REG_ADDR,
  input wire logic [7:0] REG_WDATA,
  input wire logic REG_WR,
  output logic [7:0] REG_RDATA,
  // Timebase, sixteen pulses per chip.
  input wire logic CHIP_TICK16,
  // Receiver state from the rest of the chip.
  input wire logic WAKEUP_SEARCH,
  input wire logic PESSIMISTIC,
  input wire logic [1:0] GAIN_SW_FLAGS,
  input wire logic [7:0] RX_GAIN_REG,
  input wire logic IF_VALID,
  input wire logic [7:0] RSSI_IN,
  // Demodulator outputs and slicer.
  input wire logic [DW-1:0] ASK_DEMOD,
  input wire logic [DW-1:0] FSK_DEMOD,
  input wire logic SLICER_IN,
  // Baseband and gain controls.
  output logic [DW-1:0] BB_FILTER_IN,
  output logic [8:0] CHAN_BW_KHZ,
  output logic BW_RESERVED,
  output logic [3:0] RSSI_CORNER_SEL,
  output logic [3:0] BB_FILTER_CORNER,
  output logic LOW_GAIN,
  output logic [3:0] RX_GAIN_CODE,
  // RSSI results, settling and measure status, and sliced data.
  output logic [7:0] RSSI_ADJ,
  output logic RSSI_ABOVE_UPPER,
  output logic RSSI_BELOW_LOWER,
  output logic BB_VALID,
  output logic MEASURE_EN,
  output logic SLICED_DATA
);
  // ==========================================================================
  // Register storage.
  logic [7:0] bw_q; // Bandwidth, path and RSSI corner.
  logic [6:0] ofs_q; // Low gain RSSI offset; bit 7 is fixed at zero.
  logic [7:0] gsw_q; // Gain switching threshold.
  logic [7:0] up_q; // Upper RSSI threshold.
  logic [7:0] lo_q; // Lower RSSI threshold.
  logic [7:0] bbc_q; // Baseband chain control.
  logic low_gain_q; // Current gain mode, set means low gain.
  logic [8:0] rssi_sum; // Unsaturated RSSI plus offset.
  logic [7:0] rssi_d; // Saturated adjusted RSSI.
  logic [3:0] tick_cnt_q; // Ticks within the current chip.
  logic chip_pulse; // One cycle at each chip boundary.
  logic [3:0] chip_cnt_q; // Chips elapsed while settling.
  logic [3:0] settle_chips; // Required settling chips.
  rxbg_pkg::rxbg_settle_t st_q; // Settling sequencer state.

  // Decode a bandwidth code to kHz; the top two codes give zero.
  function automatic logic [8:0] bw_khz(input logic [2:0] code);
    case (code)
      3'h0: bw_khz = rxbg_pkg::BW_300;
      3'h1: bw_khz = rxbg_pkg::BW_200;
      3'h2: bw_khz = rxbg_pkg::BW_150;
      3'h3: bw_khz = rxbg_pkg::BW_100;
      3'h4: bw_khz = rxbg_pkg::BW_75;
      3'h5: bw_khz = rxbg_pkg::BW_50;
      default: bw_khz = rxbg_pkg::BW_RSVD;
    endcase
  endfunction

  // ==========================================================================
  // Register writes; a write to any other address is ignored.
  always_ff @(posedge CLK or negedge NRST) begin
    if (!NRST) begin
      bw_q <= rxbg_pkg::RST_RX_FILTER_BW;
      ofs_q <= rxbg_pkg::RST_LOW_GAIN_OFS[6:0];
      gsw_q <= rxbg_pkg::RST_GAIN_SW_TH;
      up_q <= rxbg_pkg::RST_RSSI_UPPER;
      lo_q <= rxbg_pkg::RST_RSSI_LOWER;
      bbc_q <= rxbg_pkg::RST_BB_CHAIN;
    end else if (REG_WR) begin
      case (REG_ADDR)
        rxbg_pkg::OFS_RX_FILTER_BW: bw_q <= REG_WDATA;
        rxbg_pkg::OFS_LOW_GAIN_OFS: ofs_q <= REG_WDATA[rxbg_pkg::OFS_MSB:0];
        rxbg_pkg::OFS_GAIN_SW_TH: gsw_q <= REG_WDATA;
        rxbg_pkg::OFS_RSSI_UPPER: up_q <= REG_WDATA;
        rxbg_pkg::OFS_RSSI_LOWER: lo_q <= REG_WDATA;
        rxbg_pkg::OFS_BB_CHAIN: bbc_q <= REG_WDATA;
        default: ;
      endcase
    end
  end

  // Read data is registered; unmapped addresses read zero.
  always_ff @(posedge CLK or negedge NRST) begin
    if (!NRST) begin
      REG_RDATA <= 8'h00;
    end else begin
      case (REG_ADDR)
        rxbg_pkg::OFS_RX_FILTER_BW: REG_RDATA <= bw_q;
        rxbg_pkg::OFS_LOW_GAIN_OFS: REG_RDATA <= {1'b0, ofs_q};
        rxbg_pkg::OFS_GAIN_SW_TH: REG_RDATA <= gsw_q;
        rxbg_pkg::OFS_RSSI_UPPER: REG_RDATA <= up_q;
        rxbg_pkg::OFS_RSSI_LOWER: REG_RDATA <= lo_q;
        rxbg_pkg::OFS_BB_CHAIN: REG_RDATA <= bbc_q;
        default: REG_RDATA <= 8'h00;
      endcase
    end
  end

  // ==========================================================================
  // Static configuration outputs, taken or decoded from register bits.
  assign RSSI_CORNER_SEL = bw_q[rxbg_pkg::RSSI_FC_MSB:0];
  assign BB_FILTER_CORNER = bbc_q[rxbg_pkg::BB_FC_MSB:0];
  assign CHAN_BW_KHZ = bw_khz(bw_q[rxbg_pkg::CHAN_FILTER_BW_SEL_MSB:rxbg_pkg::CHAN_FILTER_BW_SEL_LSB]);
  // Reserved codes are flagged rather than mapped, so misuse is visible.
  assign BW_RESERVED = bw_q[rxbg_pkg::CHAN_FILTER_BW_SEL_MSB] & bw_q[rxbg_pkg::CHAN_FILTER_BW_SEL_MSB-1];

  // Registered path select feeds the baseband filter from one demodulator.
  always_ff @(posedge CLK or negedge NRST) begin
    if (!NRST) begin
      BB_FILTER_IN <= '0;
    end else if (bw_q[rxbg_pkg::ASK_SEL_BIT]) begin
      BB_FILTER_IN <= ASK_DEMOD;
    end else begin
      BB_FILTER_IN <= FSK_DEMOD;
    end
  end

  // ==========================================================================
  // Gain mode: the automatic switch only ever goes high to low, and
  // leaving wakeup search returns to high gain for the next search.
  always_ff @(posedge CLK or negedge NRST) begin
    if (!NRST) begin
      low_gain_q <= 1'b0;
    end else if (!WAKEUP_SEARCH) begin
      low_gain_q <= 1'b0;
    end else if (RSSI_IN > gsw_q && GAIN_SW_FLAGS == rxbg_pkg::GAIN_SW_AUTO) begin
      low_gain_q <= 1'b1;
    end
  end
  assign LOW_GAIN = low_gain_q;
  assign RX_GAIN_CODE = low_gain_q ? RX_GAIN_REG[3:0] : RX_GAIN_REG[7:4];

  // ==========================================================================
  // RSSI correction in low gain; the sum saturates so it never wraps.
  always_comb begin
    rssi_sum = {1'b0, RSSI_IN} + (low_gain_q ? {2'b00, ofs_q} : 9'h000);
    rssi_d = rssi_sum[8] ? 8'hFF : rssi_sum[7:0];
  end

  // Classification results are only asserted while measurement is allowed.
  always_ff @(posedge CLK or negedge NRST) begin
    if (!NRST) begin
      RSSI_ADJ <= 8'h00;
      RSSI_ABOVE_UPPER <= 1'b0;
      RSSI_BELOW_LOWER <= 1'b0;
    end else begin
      RSSI_ADJ <= rssi_d;
      RSSI_ABOVE_UPPER <= MEASURE_EN && rssi_d > up_q;
      RSSI_BELOW_LOWER <= MEASURE_EN && rssi_d < lo_q;
    end
  end

  // ==========================================================================
  // Chip boundary from the sixteenth-chip timebase.
  always_ff @(posedge CLK or negedge NRST) begin
    if (!NRST) begin
      tick_cnt_q <= 4'h0;
    end else if (!IF_VALID) begin
      tick_cnt_q <= 4'h0;
    end else if (CHIP_TICK16) begin
      tick_cnt_q <= tick_cnt_q + 4'h1;
    end
  end
  assign chip_pulse = CHIP_TICK16 && ({1'b0, tick_cnt_q} == rxbg_pkg::TICKS_PER_CHIP - 5'h01);
  assign settle_chips = {1'b0, bbc_q[rxbg_pkg::SETTLE_MSB:rxbg_pkg::SETTLE_LSB], 1'b0} + 4'h2;

  // Settling sequencer: counts chips after IF valid, restarts when it drops.
  always_ff @(posedge CLK or negedge NRST) begin
    if (!NRST) begin
      st_q <= rxbg_pkg::SET_IDLE;
      chip_cnt_q <= 4'h0;
    end else if (!IF_VALID) begin
      st_q <= rxbg_pkg::SET_IDLE;
      chip_cnt_q <= 4'h0;
    end else begin
      case (st_q)
        rxbg_pkg::SET_IDLE: st_q <= rxbg_pkg::SET_WAIT;
        rxbg_pkg::SET_WAIT: begin
          if (chip_pulse) begin
            chip_cnt_q <= chip_cnt_q + 4'h1;
            if (chip_cnt_q + 4'h1 >= settle_chips) begin
              st_q <= rxbg_pkg::SET_DONE;
            end
          end
        end
        rxbg_pkg::SET_DONE: st_q <= rxbg_pkg::SET_DONE;
        default: st_q <= rxbg_pkg::SET_IDLE;
      endcase
    end
  end
  assign BB_VALID = (st_q == rxbg_pkg::SET_DONE);
  // Pessimistic search waits for the settled baseband before measuring.
  assign MEASURE_EN = PESSIMISTIC ? BB_VALID : IF_VALID;

  // ==========================================================================
  // Deglitcher on the slicer output.
  rxbg_deglitch u_deglitch (
    .clk(CLK),
    .nrst(NRST),
    .tick16(CHIP_TICK16),
    .hold_len(bbc_q[rxbg_pkg::HOLD_MSB:rxbg_pkg::HOLD_LSB]),
    .slicer_in(SLICER_IN),
    .data_out(SLICED_DATA)
  );
endmodule
`default_nettype wire

// [test/rxbg_props.sv]
// Checker of the receive baseband and gain configuration block ports.
`timescale 1ns/1ps
`default_nettype none
module rxbg_props #(
  parameter int DW = 16
) (
  // Clock, reset and register port.
  input wire logic CLK,
  input wire logic NRST,
  input wire logic [7:0] REG_ADDR,
  input wire logic [7:0] REG_WDATA,
  input wire logic REG_WR,
  // Receiver state and demodulator data.
  input wire logic WAKEUP_SEARCH,
  input wire logic PESSIMISTIC,
  input wire logic [1:0] GAIN_SW_FLAGS,
  input wire logic [7:0] RX_GAIN_REG,
  input wire logic IF_VALID,
  input wire logic [7:0] RSSI_IN,
  input wire logic [DW-1:0] ASK_DEMOD,
  input wire logic [DW-1:0] FSK_DEMOD,
  // Watched outputs.
  input wire logic [DW-1:0] BB_FILTER_IN,
  input wire logic BW_RESERVED,
  input wire logic [3:0] RSSI_CORNER_SEL,
  input wire logic [3:0] BB_FILTER_CORNER,
  input wire logic LOW_GAIN,
  input wire logic [3:0] RX_GAIN_CODE,
  input wire logic [7:0] RSSI_ADJ,
  input wire logic BB_VALID,
  input wire logic MEASURE_EN
);
  // ==========================================================================
  // Shadow registers, indexed by address bits 2 to 0 (values 2 to 7).
  logic [7:0] sh_q [2:7];
  // Nine-bit sum, so that a carry into saturation is visible.
  logic [8:0] sum_w;
  assign sum_w = {1'b0, RSSI_IN} + {2'b00, (LOW_GAIN ? sh_q[3][6:0] : 7'h00)};
  // The shadow follows writes on the same edge as the design, so no skew appears.
  always_ff @(posedge CLK or negedge NRST) begin
    if (!NRST) begin
      for (int i = 2; i < 8; i++) begin
        sh_q[i] <= 8'h00;
      end
    end else if (REG_WR && REG_ADDR >= 8'h22 && REG_ADDR <= 8'h27) begin
      sh_q[REG_ADDR[2:0]] <= REG_WDATA;
    end
  end
  // ==========================================================================
  // Properties, all on the one clock.
  default clocking cb @(posedge CLK);
  endclocking
  default disable iff (!NRST);
  rsvd_bw_a: assert property (BW_RESERVED == (sh_q[2][6:5] == 2'b11))
    else $error("reserved bandwidth flag wrong");
  rssi_corner_a: assert property (RSSI_CORNER_SEL == sh_q[2][3:0])
    else $error("RSSI corner select wrong");
  bb_corner_a: assert property (BB_FILTER_CORNER == sh_q[7][3:0])
    else $error("baseband corner wrong");
  // The guard skips the first edge after reset, where the past is the reset state.
  path_sel_a: assert property ($past(NRST) |->
    BB_FILTER_IN == $past(sh_q[2][7] ? ASK_DEMOD : FSK_DEMOD))
    else $error("baseband input path wrong");
  gain_code_a: assert property (RX_GAIN_CODE == (LOW_GAIN ? RX_GAIN_REG[3:0] : RX_GAIN_REG[7:4]))
    else $error("gain code wrong");
  gain_switch_a: assert property (WAKEUP_SEARCH && RSSI_IN > sh_q[4] && GAIN_SW_FLAGS == 2'h1
    |=> LOW_GAIN)
    else $error("gain did not switch low");
  gain_cause_a: assert property ($rose(LOW_GAIN) |-> $past(GAIN_SW_FLAGS) == 2'h1)
    else $error("gain switched without flags");
  rssi_offset_a: assert property ($past(NRST) |->
    RSSI_ADJ == $past(sum_w[8] ? 8'hFF : sum_w[7:0]))
    else $error("adjusted RSSI wrong");
  measure_sel_a: assert property (MEASURE_EN == (PESSIMISTIC ? BB_VALID : IF_VALID))
    else $error("measurement enable wrong");
  settle_clear_a: assert property (!IF_VALID |=> !BB_VALID)
    else $error("baseband valid without IF valid");
endmodule
bind rxbg_top rxbg_props #(.DW(DW)) rxbg_props_i (.*);
`default_nettype wire

// [test/tb.sv]
// Self-checking bench of the receive baseband and gain configuration block.
`timescale 1ns/1ps
`default_nettype none
`define CHK(a, e) begin n_tests++; if ((a) !== (e)) begin error_cnt++; \
  $display("[FAIL] %0t got %h exp %h", $time, (a), (e)); end end
module tb;
  // ==========================================================================
  // Design ports, named as the top module names them.
  logic CLK, NRST, REG_WR, CHIP_TICK16, WAKEUP_SEARCH, PESSIMISTIC, IF_VALID;
  logic SLICER_IN, BW_RESERVED, LOW_GAIN, RSSI_ABOVE_UPPER, RSSI_BELOW_LOWER;
  logic BB_VALID, MEASURE_EN, SLICED_DATA;
  logic [7:0] REG_ADDR, REG_WDATA, REG_RDATA, RX_GAIN_REG, RSSI_IN, RSSI_ADJ;
  logic [1:0] GAIN_SW_FLAGS;
  logic [15:0] ASK_DEMOD, FSK_DEMOD, BB_FILTER_IN;
  logic [8:0] CHAN_BW_KHZ;
  logic [3:0] RSSI_CORNER_SEL, BB_FILTER_CORNER, RX_GAIN_CODE;
  int error_cnt = 0;
  int n_tests = 0;
  rxbg_top #(.DW(16)) rxbg_top_i (.*);
  // The clock toggles every half period of 5 ns.
  initial begin
    CLK = 1'b0;
    forever #5 CLK = ~CLK;
  end
  // ==========================================================================
  // Helpers; inputs always move 1 ns after a rising edge.
  task automatic cyc(input int n);
    repeat (n) @(posedge CLK);
    #1;
  endtask
  // A write spends a second cycle low so back-to-back strobes never collide.
  task automatic wr(input logic [7:0] a, input logic [7:0] d);
    REG_ADDR = a;
    REG_WDATA = d;
    REG_WR = 1'b1;
    cyc(1);
    REG_WR = 1'b0;
    cyc(1);
  endtask
  task automatic rd(input logic [7:0] a, input logic [7:0] e);
    REG_ADDR = a;
    cyc(1);
    `CHK(REG_RDATA, e)
  endtask
  // One timebase pulse per two cycles.
  task automatic tk(input int n);
    repeat (n) begin
      CHIP_TICK16 = 1'b1;
      cyc(1);
      CHIP_TICK16 = 1'b0;
      cyc(1);
    end
  endtask
  task automatic end_sim();
    $display("Checks %0d, mismatches %0d", n_tests, error_cnt);
    if (error_cnt == 0 && n_tests > 0) begin
      $display("Test passed");
    end else begin
      $display("Test failed");
    end
    $finish;
  endtask
  // ==========================================================================
  // Reset values, read back, the reserved bit and an unmapped address.
  task automatic t_regs();
    for (int a = 8'h22; a <= 8'h27; a++) begin
      rd(8'(a), 8'h00);
    end
    for (int a = 8'h22; a <= 8'h27; a++) begin
      wr(8'(a), 8'(a) ^ 8'hF0);
      rd(8'(a), (a == 8'h23) ? 8'h53 : 8'(a) ^ 8'hF0);
    end
    wr(8'h30, 8'hFF);
    rd(8'h30, 8'h00);
    $display("t_regs done");
  endtask
  // Every bandwidth code, corner select and the demodulator path.
  task automatic t_bw();
    logic [8:0] tab [8] = '{9'h12C, 9'h0C8, 9'h096, 9'h064, 9'h04B, 9'h032, 9'h000, 9'h000};
    for (int c = 0; c < 8; c++) begin
      wr(8'h22, {1'b0, 3'(c), 4'(15 - c)});
      `CHK(CHAN_BW_KHZ, tab[c])
      `CHK(BW_RESERVED, (c > 5))
      `CHK(RSSI_CORNER_SEL, 4'(15 - c))
    end
    wr(8'h22, 8'h80);
    cyc(1);
    `CHK(BB_FILTER_IN, 16'hA5A5)
    wr(8'h22, 8'h00);
    cyc(1);
    `CHK(BB_FILTER_IN, 16'h5A5A)
    $display("t_bw done");
  endtask
  // Automatic gain switch at the threshold boundary and the low-gain offset.
  task automatic t_gain();
    wr(8'h23, 8'h85);
    wr(8'h24, 8'h40);
    WAKEUP_SEARCH = 1'b1;
    RSSI_IN = 8'h50;
    cyc(3);
    `CHK(LOW_GAIN, 1'b0)
    `CHK(RX_GAIN_CODE, 4'h9)
    `CHK(RSSI_ADJ, 8'h50)
    GAIN_SW_FLAGS = 2'h1;
    RSSI_IN = 8'h40;
    cyc(3);
    `CHK(LOW_GAIN, 1'b0)
    RSSI_IN = 8'h41;
    cyc(1);
    `CHK(LOW_GAIN, 1'b1)
    `CHK(RX_GAIN_CODE, 4'hC)
    cyc(1);
    `CHK(RSSI_ADJ, 8'h46)
    RSSI_IN = 8'hFE;
    cyc(2);
    `CHK(RSSI_ADJ, 8'hFF)
    WAKEUP_SEARCH = 1'b0;
    cyc(2);
    `CHK(LOW_GAIN, 1'b0)
    `CHK(RX_GAIN_CODE, 4'h9)
    $display("t_gain done");
  endtask
  // Upper and lower classification on both sides of each threshold.
  task automatic t_thresh();
    logic [7:0] v [4] = '{8'h70, 8'h60, 8'h1F, 8'h20};
    wr(8'h25, 8'h60);
    wr(8'h26, 8'h20);
    IF_VALID = 1'b1;
    for (int i = 0; i < 4; i++) begin
      RSSI_IN = v[i];
      cyc(3);
      `CHK(RSSI_ABOVE_UPPER, (v[i] > 8'h60))
      `CHK(RSSI_BELOW_LOWER, (v[i] < 8'h20))
    end
    $display("t_thresh done");
  endtask
  // Settling delay of 2(1+n) chips, one tick per cycle, and the measure gate.
  task automatic t_settle();
    int cnt;
    CHIP_TICK16 = 1'b1;
    PESSIMISTIC = 1'b1;
    // A level above the upper threshold shows whether classification waits.
    RSSI_IN = 8'h70;
    for (int n = 0; n < 4; n += 3) begin
      IF_VALID = 1'b0;
      wr(8'h27, {2'b00, 2'(n), 4'h0});
      IF_VALID = 1'b1;
      cyc(1);
      `CHK(MEASURE_EN, 1'b0)
      `CHK(RSSI_ABOVE_UPPER, 1'b0)
      cnt = 1;
      while (BB_VALID !== 1'b1 && cnt < 400) begin
        cyc(1);
        cnt++;
      end
      if (cnt >= 400) begin
        error_cnt++;
        end_sim();
      end
      `CHK((cnt >= 32 * (n + 1) && cnt <= 32 * (n + 1) + 3), 1'b1)
      `CHK(MEASURE_EN, 1'b1)
      cyc(1);
      `CHK(RSSI_ABOVE_UPPER, 1'b1)
    end
    CHIP_TICK16 = 1'b0;
    $display("t_settle done");
  endtask
  // Hold-off of 0, 2, 3 and 4 ticks after an accepted transition.
  task automatic t_glitch();
    for (int k = 0; k < 4; k++) begin
      wr(8'h27, {2'(k), 6'h0B});
      `CHK(BB_FILTER_CORNER, 4'hB)
      tk(4);
      SLICER_IN = ~SLICER_IN;
      cyc(2);
      `CHK(SLICED_DATA, SLICER_IN)
      SLICER_IN = ~SLICER_IN;
      tk(k);
      if (k > 0) begin
        `CHK(SLICED_DATA, ~SLICER_IN)
      end
      // One more tick ends the lock exactly, so a lock one tick too long fails here.
      tk(1);
      `CHK(SLICED_DATA, SLICER_IN)
    end
    $display("t_glitch done");
  endtask
  // ==========================================================================
  // Main sequence: reset for 12 cycles, then each scenario in turn.
  initial begin
    {NRST, REG_WR, CHIP_TICK16, WAKEUP_SEARCH, PESSIMISTIC, IF_VALID, SLICER_IN} = 7'h00;
    {REG_ADDR, REG_WDATA, RSSI_IN, GAIN_SW_FLAGS} = 26'h000_0002;
    RX_GAIN_REG = 8'h9C;
    ASK_DEMOD = 16'hA5A5;
    FSK_DEMOD = 16'h5A5A;
    cyc(12);
    NRST = 1'b1;
    t_regs();
    t_bw();
    t_gain();
    t_thresh();
    t_settle();
    t_glitch();
    end_sim();
  end
endmodule
`default_nettype wire
